// File: hw/prlc_map.svh
// prlc_map.svh: bit positions, select codes and reset values of the
// serial latch words. Assumes a 24-bit word with the select pair in bits 1:0.
`ifndef PRLC_MAP_SVH
`define PRLC_MAP_SVH

`define PRLC_WORD_BITS 24
`define PRLC_SEL_CTRL 2'h0
`define PRLC_SEL_REF 2'h1
`define PRLC_SEL_FB 2'h2
`define PRLC_SEL_TEST 2'h3
`define PRLC_CTRL_GAIN_BIT 10
`define PRLC_FB_GAIN_BIT 21
`define PRLC_FB_COUNT_LSB 8
`define PRLC_FB_COUNT_MSB 20
`define PRLC_REF_DIV_LSB 2
`define PRLC_REF_DIV_MSB 15
`define PRLC_REF_ABP_LSB 16
`define PRLC_REF_ABP_MSB 17
`define PRLC_REF_LDP_BIT 18
`define PRLC_REF_TMB_BIT 19
`define PRLC_REF_BSC_LSB 20
`define PRLC_REF_BSC_MSB 21
`define PRLC_LOCK_CNT_LO 3'h3
`define PRLC_LOCK_CNT_HI 3'h5
`define PRLC_REF_DIV_RESET 14'h0001
`define PRLC_FB_COUNT_RESET 13'h0003

`endif

// File: hw/prlc_pkg.sv
// prlc_pkg: types shared by the latch bank.
// assumes the map header is compiled alongside.
`default_nettype none
package prlc_pkg;
  typedef logic [23:0] prlc_word_t;
  typedef enum logic [1:0] {
    PRLC_BSC_DIV1,
    PRLC_BSC_DIV2,
    PRLC_BSC_DIV4,
    PRLC_BSC_DIV8
  } prlc_bsc_e;
endpackage : prlc_pkg
`default_nettype wire

// File: hw/prlc_top.sv
// prlc_top: serial-programmed configuration latches of a clock PLL.
// assumes serial clock, data, load strobe and the pfd timing inputs are
// already synchronous to core_clk_i.
`include "prlc_map.svh"
`default_nettype none

// How it works
// - feedback word bit 21 picks pump current
// - one gain bit, latest write wins
// - select pair 0,1 loads reference latch
// - fourteen-bit reference divide ratio, 1 to 16383
// - bits 16-17 choose antibacklash width
// - bit 18 picks five or three lock cycles
// - bit 19 sets the test enable flag only; the test latch loads whatever its value
// - band clock from divider, optional extra division
// - feedback ratio only from feedback latch
// - 24 bits shifted, strobe rise loads latch
// - select pair 0,0 loads control latch
module prlc_top import prlc_pkg::*; (
  input wire logic core_clk_i, // 100 MHz core clock
  input wire logic sys_rst_i, // synchronous reset, active high
  input wire logic serial_clk_i, // serial clock from host
  input wire logic serial_data_i, // serial data, msb first
  input wire logic load_strobe_i, // load strobe, rising edge latches
  input wire logic ref_cycle_i, // one pulse per reference divider cycle
  input wire logic phase_ok_i, // phase error inside window this cycle
  output logic [13:0] reference_divide_value_o, // reference ratio
  output logic [1:0] antibacklash_o, // antibacklash width code
  output logic lock_precision_select_o, // 1: five cycles
  output logic factory_test_enable_o, // test enable flag, reference word bit 19
  output logic [1:0] band_clock_div_o, // band clock divider code
  output logic pump_current_select_o, // 1: current setting two
  output logic [12:0] feedback_count_o, // feedback divide ratio
  output logic [23:0] control_word_o, // last control latch word
  output logic [23:0] test_word_o, // last test latch word
  output logic band_clk_tick_o, // band-select clock pulse
  output logic lock_detect_o // digital lock indication
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    prlc_word_t shift;
    logic sclk_d;
    logic le_d;
    logic [13:0] ref_div;
    logic [1:0] abp;
    logic lock_precision_select;
    logic factory_test_enable;
    logic [1:0] bsc;
    logic gain;
    logic [12:0] fb_count;
    prlc_word_t ctrl;
    prlc_word_t test;
    logic [2:0] bsc_cnt;
    logic bsc_tick;
    logic [2:0] lock_cnt;
    logic lock;
  } prlc_state_s;

  prlc_state_s st;
  prlc_state_s next_st;

  // last count value (ratio minus one) of the optional band clock division for a code
  function automatic logic [2:0] prlc_bsc_last(input logic [1:0] code);
    case (prlc_bsc_e'(code))
      PRLC_BSC_DIV2: prlc_bsc_last = 3'h1;
      PRLC_BSC_DIV4: prlc_bsc_last = 3'h3;
      PRLC_BSC_DIV8: prlc_bsc_last = 3'h7;
      default: prlc_bsc_last = 3'h0;
    endcase
  endfunction : prlc_bsc_last

  logic sclk_rise;
  logic le_rise;
  logic [1:0] sel;
  logic [2:0] lock_need;

  assign sclk_rise = serial_clk_i & ~st.sclk_d;
  assign le_rise = load_strobe_i & ~st.le_d;
  assign sel = st.shift[1:0];
  assign lock_need = st.lock_precision_select ? `PRLC_LOCK_CNT_HI : `PRLC_LOCK_CNT_LO;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sclk_d = serial_clk_i;
    next_st.le_d = load_strobe_i;
    // shift on each rising serial clock, only the last 24 bits count
    if (sclk_rise) begin
      next_st.shift = {st.shift[22:0], serial_data_i};
    end
    // strobe rise moves the word into the selected latch
    if (le_rise) begin
      case (sel)
        `PRLC_SEL_CTRL: begin
          next_st.ctrl = st.shift;
          next_st.gain = st.shift[`PRLC_CTRL_GAIN_BIT];
        end
        `PRLC_SEL_REF: begin
          // a zero ratio is illegal; keep the old one
          if (st.shift[`PRLC_REF_DIV_MSB:`PRLC_REF_DIV_LSB] != 14'h0000) begin
            next_st.ref_div =
              st.shift[`PRLC_REF_DIV_MSB:`PRLC_REF_DIV_LSB];
          end
          next_st.abp = st.shift[`PRLC_REF_ABP_MSB:`PRLC_REF_ABP_LSB];
          next_st.lock_precision_select = st.shift[`PRLC_REF_LDP_BIT];
          next_st.factory_test_enable = st.shift[`PRLC_REF_TMB_BIT];
          next_st.bsc = st.shift[`PRLC_REF_BSC_MSB:`PRLC_REF_BSC_LSB];
          next_st.bsc_cnt = 3'h0;
          // bits 23-22 are reserved and dropped
        end
        `PRLC_SEL_FB: begin
          next_st.fb_count =
            st.shift[`PRLC_FB_COUNT_MSB:`PRLC_FB_COUNT_LSB];
          next_st.gain = st.shift[`PRLC_FB_GAIN_BIT];
        end
        `PRLC_SEL_TEST: begin
          next_st.test = st.shift;
        end
        default: begin
          next_st.test = st.test;
        end
      endcase
    end
    // band clock: one tick per reference cycle, or per N when divided
    next_st.bsc_tick = 1'b0;
    if (ref_cycle_i) begin
      if (st.bsc_cnt >= prlc_bsc_last(st.bsc)) begin
        next_st.bsc_cnt = 3'h0;
        next_st.bsc_tick = 1'b1;
      end else begin
        next_st.bsc_cnt = st.bsc_cnt + 3'h1;
      end
    end
    // lock detect counts good reference cycles in a row
    if (ref_cycle_i) begin
      if (!phase_ok_i) begin
        next_st.lock_cnt = 3'h0;
        next_st.lock = 1'b0;
      end else if (st.lock_cnt < lock_need) begin
        next_st.lock_cnt = st.lock_cnt + 3'h1;
        next_st.lock = (st.lock_cnt + 3'h1) >= lock_need;
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.ref_div <= `PRLC_REF_DIV_RESET;
      st.fb_count <= `PRLC_FB_COUNT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops; the test word is only stored,
  // nothing acts on it, so it cannot disturb normal operation
  assign reference_divide_value_o = st.ref_div;
  assign antibacklash_o = st.abp;
  assign lock_precision_select_o = st.lock_precision_select;
  assign factory_test_enable_o = st.factory_test_enable;
  assign band_clock_div_o = st.bsc;
  assign pump_current_select_o = st.gain;
  assign feedback_count_o = st.fb_count;
  assign control_word_o = st.ctrl;
  assign test_word_o = st.test;
  assign band_clk_tick_o = st.bsc_tick;
  assign lock_detect_o = st.lock;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking chk_cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // plain load flags: a sequence cannot be negated, these can
  logic fb_load;
  logic ctrl_load;
  logic ref_load;
  assign fb_load = le_rise && sel == `PRLC_SEL_FB;
  assign ctrl_load = le_rise && sel == `PRLC_SEL_CTRL;
  assign ref_load = le_rise && sel == `PRLC_SEL_REF;

  sequence fb_load_s;
    fb_load;
  endsequence

  sequence ctrl_load_s;
    ctrl_load;
  endsequence

  fb_gain_a: assert property (
    fb_load_s |=>
      pump_current_select_o == $past(st.shift[`PRLC_FB_GAIN_BIT]))
    else $error("feedback gain bit not taken");
  ctrl_gain_a: assert property (
    ctrl_load_s |=>
      pump_current_select_o == $past(st.shift[`PRLC_CTRL_GAIN_BIT]))
    else $error("control gain bit not taken");
  gain_hold_a: assert property (
    !(le_rise && !sel[0]) |=> $stable(pump_current_select_o))
    else $error("gain changed without a load");
  ref_load_a: assert property (
    ref_load |=> lock_precision_select_o == $past(st.shift[18])
      && antibacklash_o == $past(st.shift[17:16])
      && factory_test_enable_o == $past(st.shift[19])
      && band_clock_div_o == $past(st.shift[21:20]))
    else $error("reference latch not loaded");
  ref_div_a: assert property (
    reference_divide_value_o != 14'h0000)
    else $error("reference ratio zero");
  ref_guard_a: assert property (
    !ref_load |=> $stable(reference_divide_value_o))
    else $error("reference latch loaded by another select");
  lock_need_a: assert property (
    $rose(lock_detect_o) |->
      $past(st.lock_cnt) + 3'h1 == $past(lock_need))
    else $error("lock declared at wrong count");
  fb_only_a: assert property (
    !fb_load |=> $stable(feedback_count_o))
    else $error("feedback ratio changed outside its latch");
  test_hold_a: assert property (
    !le_rise |=> $stable(test_word_o) && $stable(factory_test_enable_o))
    else $error("test state changed without a load");
  ctrl_load_a: assert property (
    ctrl_load_s |=> control_word_o == $past(st.shift))
    else $error("control latch not loaded");
  shift_a: assert property (
    sclk_rise |=> st.shift[0] == $past(serial_data_i))
    else $error("serial bit not shifted");
  bsc_a: assert property (
    band_clk_tick_o |-> $past(ref_cycle_i))
    else $error("band tick without reference cycle");
  lock_drop_a: assert property (
    ref_cycle_i && !phase_ok_i |=> !lock_detect_o && st.lock_cnt == 3'h0)
    else $error("lock kept after phase error");

endmodule : prlc_top
`default_nettype wire

// File: tb/prlc_host.sv
// prlc_host: host side of the three-wire latch programming link.
// assumes it is driven from the falling edge of the core clock.
`default_nettype none
module prlc_host (
  input wire logic core_clk_i, // bench core clock
  output var logic serial_clk_o, // serial clock, idle low
  output var logic serial_data_o, // serial data, msb first
  output var logic load_strobe_o // load strobe, rises after 24 bits
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clk_o = 1'b0;
    serial_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  // ----------------------------------------
  // one word transfer
  // ----------------------------------------
  // reference words get reserved and test bits cleared; strict picks
  // divide by eight whenever the band divider is switched on
  task automatic send(input logic [23:0] w, input logic strict);
    logic [23:0] v;
    v = w;
    if (v[1:0] == 2'h1) begin
      v[23:22] = 2'h0;
      v[19] = 1'b0;
      if (strict && v[21:20] != 2'h0) v[21:20] = 2'h3;
    end
    for (int i = 23; i >= 0; i--) begin
      @(negedge core_clk_i);
      serial_clk_o = 1'b0;
      serial_data_o = v[i];
      @(negedge core_clk_i);
      serial_clk_o = 1'b1;
    end
    @(negedge core_clk_i);
    serial_clk_o = 1'b0;
    serial_data_o = ~v[0]; // no stale bit left on the line
    load_strobe_o = 1'b1;
    @(negedge core_clk_i);
    load_strobe_o = 1'b0;
  endtask : send
endmodule : prlc_host
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: random and corner-case checks of the latch bank.
// assumes prlc_top and the host model are compiled before it.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclk, sdat, strobe, lock_precision_select, factory_test_enable, gain, tick, lock;
  logic ref_cyc = 1'b0;
  logic ph_ok = 1'b0;
  logic [13:0] ref_div;
  logic [1:0] abp, bsc;
  logic [12:0] fb_cnt;
  logic [23:0] ctrl_w, test_w, w;
  int error_cnt = 0;
  int samples_checked = 0;
  int ticks = 0;
  int seed = 64;
  always #5 core_clk = ~core_clk;
  // counted on the falling edge, half a cycle after launch, so the tick is settled when seen
  always @(negedge core_clk) if (tick === 1'b1) ticks++;
  prlc_host i_host (.core_clk_i(core_clk), .serial_clk_o(sclk),
    .serial_data_o(sdat), .load_strobe_o(strobe));
  prlc_top i_dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
    .serial_clk_i(sclk), .serial_data_i(sdat), .load_strobe_i(strobe),
    .ref_cycle_i(ref_cyc), .phase_ok_i(ph_ok),
    .reference_divide_value_o(ref_div), .antibacklash_o(abp),
    .lock_precision_select_o(lock_precision_select), .factory_test_enable_o(factory_test_enable),
    .band_clock_div_o(bsc), .pump_current_select_o(gain),
    .feedback_count_o(fb_cnt), .control_word_o(ctrl_w),
    .test_word_o(test_w), .band_clk_tick_o(tick), .lock_detect_o(lock));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc
  // one reference cycle, then a quiet cycle so pulses never merge
  task automatic pulse(input logic ok);
    ref_cyc = 1'b1;
    ph_ok = ok;
    @(negedge core_clk);
    ref_cyc = 1'b0;
    @(negedge core_clk);
  endtask : pulse
  function automatic logic [23:0] mkref(logic [13:0] r, logic [1:0] a,
      logic l, logic [1:0] b);
    return {2'h0, b, 1'b0, l, a, r, 2'h1};
  endfunction : mkref
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [13:0] r;
    wait_cyc(20);
    sys_rst = 1'b0;
    wait_cyc(1);
    chk(ref_div, 14'h0001);
    chk(fb_cnt, 13'h0003);
    chk({lock, gain, lock_precision_select, abp}, 5'h00);
    // random reference words with both ratio extremes up front
    for (int k = 0; k < 12; k++) begin
      r = 14'($random(seed));
      if (r == 14'h0) r = 14'h3FFF;
      w = mkref(r, 2'($random(seed)), 1'($random(seed)), 2'($random(seed)));
      if (k == 0) w = mkref(14'h3FFF, 2'h3, 1'b1, 2'h2);
      if (k == 1) w = mkref(14'h0001, 2'h0, 1'b0, 2'h0);
      i_host.send(w, 1'b1);
      wait_cyc(2);
      chk(ref_div, w[15:2]);
      chk(abp, w[17:16]);
      chk(lock_precision_select, w[18]);
      chk(factory_test_enable, 1'b0);
      chk(bsc, (w[21:20] == 2'h0) ? 2'h0 : 2'h3);
    end
    i_host.send(mkref(14'h0000, 2'h1, 1'b0, 2'h0), 1'b0);
    wait_cyc(2);
    chk(ref_div, w[15:2]);
    // gain bit from both sources, each write flipping the last one
    for (int g = 0; g < 4; g++) begin
      w = g[0] ? {12'h2B4, g[1], !g[0], 8'hC6, 2'h0} :
        {2'h0, !g[0], 13'h1ABC, 6'h0, 2'h2};
      i_host.send(w, 1'b0);
      wait_cyc(2);
      chk(gain, !g[0]);
      if (g[0]) chk(ctrl_w, w);
    end
    chk(fb_cnt, 13'h1ABC);
    i_host.send(24'hA5A5A7, 1'b0);
    wait_cyc(2);
    chk(test_w, 24'hA5A5A7);
    // lock needs exactly three or five good cycles in a row
    for (int m = 0; m < 2; m++) begin
      i_host.send(mkref(14'h0010, 2'h0, m[0], 2'h0), 1'b0);
      wait_cyc(2);
      pulse(1'b0);
      repeat (m ? 4 : 2) pulse(1'b1);
      wait_cyc(2);
      chk(lock, 1'b0);
      pulse(1'b1);
      wait_cyc(2);
      chk(lock, 1'b1);
      pulse(1'b0);
      wait_cyc(2);
      chk(lock, 1'b0);
    end
    // 32 cycles give whole tick counts whatever the divider phase
    for (int b = 0; b < 4; b++) begin
      i_host.send(mkref(14'h0010, 2'h0, 1'b0, b[1:0]), 1'b0);
      wait_cyc(2);
      ticks = 0;
      repeat (32) pulse(1'b1);
      wait_cyc(2);
      chk(24'(ticks), 24'(32 >> b));
    end
    end_sim();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
